// File: swg_window_timing_gain_regs.sv
`timescale 1ns/1ps
// Functional notes
// - first-row register holds start row 8:1
// - last-row register 0x0f, resets 0xfb
// - first-column register 0x10, resets 0x00
// - last-column register 0x11, resets 0xa5
// - low-bits 0/1 give row LSBs
// - low-bits 3:2, 5:4 give column pairs
// - low-bits resets 0x32; bit6 adds one
// - 12-bit exposure rows at 0x13/0x14
// - 11-bit line gap at 0x15/0x16
// - 12-bit frame gap, low at 0x18
// - overall gain 0x19, code to log gain
// - red gain 0x1c, linear, resets zero
// - blue 0x1a, green 0x1b linear gains
// - scan start and end rows plus one when bit6
module swg_window_timing_gain_regs
    import swg_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire swg_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [8:0] scan_row_start_raw,
    input wire logic [8:0] scan_row_end_raw,
    output swg_cfg_t cfg,
    output logic [9:0] scan_row_start,
    output logic [9:0] scan_row_end
);

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [7:0] reg_q [NUM_REGS];
    logic [7:0] reg_d [NUM_REGS];
    logic [NUM_REGS-1:0] wr_hit;

    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        assign wr_hit[i] = reg_req.wr && (reg_req.addr == REG_OFFSET[i]);

        always_comb begin
            reg_d[i] = reg_q[i];
            if (wr_hit[i]) begin
                reg_d[i] = reg_req.wdata & REG_MASK[i];
            end
        end

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                reg_q[i] <= REG_RESET[i];
            end else begin
                reg_q[i] <= reg_d[i];
            end
        end
    end

    // ==========================================================
    // Read-back
    // ==========================================================
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;

    // Unmapped offsets answer zero rather than floating old data
    always_comb begin
        rdata_d = 8'h00;
        rvalid_d = reg_req.rd;
        if (reg_req.rd) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                if (reg_req.addr == REG_OFFSET[k]) begin
                    rdata_d = reg_q[k];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ==========================================================
    // Field assembly
    // ==========================================================
    logic [7:0] low_bits;
    swg_cfg_t cfg_d;
    swg_cfg_t cfg_q;

    assign low_bits = reg_q[IDX_WINDOW_LOW_BITS];

    always_comb begin
        cfg_d.disp_first_row_field = {reg_q[IDX_DISP_FIRST_ROW_HI], low_bits[POS_DISP_FIRST_ROW_LOW_BIT]};
        cfg_d.disp_last_row_field = {reg_q[IDX_DISP_LAST_ROW_HI], low_bits[POS_DISP_LAST_ROW_LOW_BIT]};
        cfg_d.disp_first_col_field = {reg_q[IDX_DISP_FIRST_COL_HI],
            low_bits[POS_DISP_FIRST_COL_LOW_PAIR +: 2]};
        cfg_d.disp_last_col_field = {reg_q[IDX_DISP_LAST_COL_HI],
            low_bits[POS_DISP_LAST_COL_LOW_PAIR +: 2]};
        cfg_d.exposure_rows = {reg_q[IDX_EXPOSURE_ROWS_HIGH][3:0], reg_q[IDX_EXPOSURE_ROWS_LOW]};
        cfg_d.line_gap = {reg_q[IDX_LINE_GAP_HIGH][2:0], reg_q[IDX_LINE_GAP_LOW]};
        cfg_d.frame_gap = {reg_q[IDX_FRAME_GAP_HIGH][3:0], reg_q[IDX_FRAME_GAP_LOW]};
        cfg_d.overall_gain_code = reg_q[IDX_OVERALL_VIDEO_GAIN];
        cfg_d.blue_gain_code = reg_q[IDX_BLUE_CHANNEL_GAIN];
        cfg_d.green_gain_code = reg_q[IDX_GREEN_CHANNEL_GAIN];
        cfg_d.red_gain_code = reg_q[IDX_RED_CHANNEL_GAIN];
    end

    // ==========================================================
    // Scan window row offset
    // ==========================================================
    logic [9:0] scan_start_d;
    logic [9:0] scan_end_d;
    logic [9:0] scan_start_q;
    logic [9:0] scan_end_q;

    swg_scan_row_adjust u_scan_adjust (
        .start_raw(scan_row_start_raw),
        .end_raw(scan_row_end_raw),
        .plus_one(low_bits[POS_SCAN_ROW_PLUS_ONE]),
        .start_adj(scan_start_d),
        .end_adj(scan_end_d)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '0;
            scan_start_q <= 10'h000;
            scan_end_q <= 10'h000;
        end else begin
            cfg_q <= cfg_d;
            scan_start_q <= scan_start_d;
            scan_end_q <= scan_end_d;
        end
    end

    assign cfg = cfg_q;
    assign scan_row_start = scan_start_q;
    assign scan_row_end = scan_end_q;

endmodule : swg_window_timing_gain_regs

// File: swg_pkg.sv
package swg_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int NUM_REGS = 15;

    localparam logic [7:0] OFF_DISP_FIRST_ROW_HI = 8'h0e;
    localparam logic [7:0] OFF_DISP_LAST_ROW_HI = 8'h0f;
    localparam logic [7:0] OFF_DISP_FIRST_COL_HI = 8'h10;
    localparam logic [7:0] OFF_DISP_LAST_COL_HI = 8'h11;
    localparam logic [7:0] OFF_WINDOW_LOW_BITS = 8'h12;
    localparam logic [7:0] OFF_EXPOSURE_ROWS_HIGH = 8'h13;
    localparam logic [7:0] OFF_EXPOSURE_ROWS_LOW = 8'h14;
    localparam logic [7:0] OFF_LINE_GAP_HIGH = 8'h15;
    localparam logic [7:0] OFF_LINE_GAP_LOW = 8'h16;
    localparam logic [7:0] OFF_FRAME_GAP_HIGH = 8'h17;
    localparam logic [7:0] OFF_FRAME_GAP_LOW = 8'h18;
    localparam logic [7:0] OFF_OVERALL_VIDEO_GAIN = 8'h19;
    localparam logic [7:0] OFF_BLUE_CHANNEL_GAIN = 8'h1a;
    localparam logic [7:0] OFF_GREEN_CHANNEL_GAIN = 8'h1b;
    localparam logic [7:0] OFF_RED_CHANNEL_GAIN = 8'h1c;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_DISP_FIRST_ROW_HI = 8'h00;
    localparam logic [7:0] RST_DISP_LAST_ROW_HI = 8'hfb;
    localparam logic [7:0] RST_DISP_FIRST_COL_HI = 8'h00;
    localparam logic [7:0] RST_DISP_LAST_COL_HI = 8'ha5;
    localparam logic [7:0] RST_WINDOW_LOW_BITS = 8'h32;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ==========================================================
    // Writable bit masks (reserved bits cleared)
    // ==========================================================
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_WINDOW_LOW_BITS = 8'h7f;
    localparam logic [7:0] MASK_EXPOSURE_ROWS_HIGH = 8'h0f;
    localparam logic [7:0] MASK_LINE_GAP_HIGH = 8'h07;
    localparam logic [7:0] MASK_FRAME_GAP_HIGH = 8'h0f;

    // ==========================================================
    // Register indices and tables
    // ==========================================================
    localparam int IDX_DISP_FIRST_ROW_HI = 0;
    localparam int IDX_DISP_LAST_ROW_HI = 1;
    localparam int IDX_DISP_FIRST_COL_HI = 2;
    localparam int IDX_DISP_LAST_COL_HI = 3;
    localparam int IDX_WINDOW_LOW_BITS = 4;
    localparam int IDX_EXPOSURE_ROWS_HIGH = 5;
    localparam int IDX_EXPOSURE_ROWS_LOW = 6;
    localparam int IDX_LINE_GAP_HIGH = 7;
    localparam int IDX_LINE_GAP_LOW = 8;
    localparam int IDX_FRAME_GAP_HIGH = 9;
    localparam int IDX_FRAME_GAP_LOW = 10;
    localparam int IDX_OVERALL_VIDEO_GAIN = 11;
    localparam int IDX_BLUE_CHANNEL_GAIN = 12;
    localparam int IDX_GREEN_CHANNEL_GAIN = 13;
    localparam int IDX_RED_CHANNEL_GAIN = 14;

    localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
        OFF_DISP_FIRST_ROW_HI, OFF_DISP_LAST_ROW_HI, OFF_DISP_FIRST_COL_HI,
        OFF_DISP_LAST_COL_HI, OFF_WINDOW_LOW_BITS, OFF_EXPOSURE_ROWS_HIGH,
        OFF_EXPOSURE_ROWS_LOW, OFF_LINE_GAP_HIGH, OFF_LINE_GAP_LOW,
        OFF_FRAME_GAP_HIGH, OFF_FRAME_GAP_LOW, OFF_OVERALL_VIDEO_GAIN,
        OFF_BLUE_CHANNEL_GAIN, OFF_GREEN_CHANNEL_GAIN, OFF_RED_CHANNEL_GAIN};

    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        RST_DISP_FIRST_ROW_HI, RST_DISP_LAST_ROW_HI, RST_DISP_FIRST_COL_HI,
        RST_DISP_LAST_COL_HI, RST_WINDOW_LOW_BITS, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO};

    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_WINDOW_LOW_BITS, MASK_EXPOSURE_ROWS_HIGH,
        MASK_FULL, MASK_LINE_GAP_HIGH, MASK_FULL,
        MASK_FRAME_GAP_HIGH, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL};

    // ==========================================================
    // Field positions in window_low_bits
    // ==========================================================
    localparam int POS_DISP_FIRST_ROW_LOW_BIT = 0;
    localparam int POS_DISP_LAST_ROW_LOW_BIT = 1;
    localparam int POS_DISP_FIRST_COL_LOW_PAIR = 2;
    localparam int POS_DISP_LAST_COL_LOW_PAIR = 4;
    localparam int POS_SCAN_ROW_PLUS_ONE = 6;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swg_reg_req_t;

    typedef struct packed {
        logic [8:0] disp_first_row_field;
        logic [8:0] disp_last_row_field;
        logic [9:0] disp_first_col_field;
        logic [9:0] disp_last_col_field;
        logic [11:0] exposure_rows;
        logic [10:0] line_gap;
        logic [11:0] frame_gap;
        logic [7:0] overall_gain_code;
        logic [7:0] blue_gain_code;
        logic [7:0] green_gain_code;
        logic [7:0] red_gain_code;
    } swg_cfg_t;

endpackage : swg_pkg

// File: swg_scan_row_adjust.sv
`timescale 1ns/1ps
module swg_scan_row_adjust
    import swg_pkg::*;
(
    input wire logic [8:0] start_raw,
    input wire logic [8:0] end_raw,
    input wire logic plus_one,
    output logic [9:0] start_adj,
    output logic [9:0] end_adj
);

    logic [8:0] raw [2];
    logic [9:0] adj [2];

    assign raw[0] = start_raw;
    assign raw[1] = end_raw;

    // ==========================================================
    // Per-bound increment
    // ==========================================================
    // Ten bits out so the top row plus one never wraps to zero
    for (genvar g = 0; g < 2; g++) begin : g_bound
        assign adj[g] = {1'b0, raw[g]} + {9'h000, plus_one};
    end

    assign start_adj = adj[0];
    assign end_adj = adj[1];

endmodule : swg_scan_row_adjust

// File: swg_window_timing_gain_regs_chk.sv
`timescale 1ns/1ps
module swg_window_timing_gain_regs_chk
    import swg_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire swg_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [8:0] scan_row_start_raw,
    input wire logic [8:0] scan_row_end_raw,
    input wire swg_cfg_t cfg,
    input wire logic [9:0] scan_row_start,
    input wire logic [9:0] scan_row_end
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Register port and field mapping
    // ==========================================================
    a_rvalid_after_read: assert property (reg_req.rd |=> reg_rvalid) else $error("read without valid");
    a_unmapped_reads_zero: assert property (reg_req.rd && !(reg_req.addr inside {[8'h0e:8'h1c]})
        |=> reg_rvalid && reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_reserved_reads_zero: assert property (reg_req.rd && reg_req.addr == 8'h15 |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved bits not zero");
    a_first_row_hi: assert property (reg_req.wr && reg_req.addr == 8'h0e
        |-> ##2 cfg.disp_first_row_field[8:1] == $past(reg_req.wdata, 2)) else $error("first row field wrong");
    a_last_col_hi: assert property (reg_req.wr && reg_req.addr == 8'h11
        |-> ##2 cfg.disp_last_col_field[9:2] == $past(reg_req.wdata, 2)) else $error("last col field wrong");
    a_low_bits_map: assert property (reg_req.wr && reg_req.addr == 8'h12 |-> ##2
        {cfg.disp_last_col_field[1:0], cfg.disp_first_col_field[1:0], cfg.disp_last_row_field[0],
        cfg.disp_first_row_field[0]} == $past(reg_req.wdata[5:0], 2)) else $error("low bits misplaced");
    a_exposure_high: assert property (reg_req.wr && reg_req.addr == 8'h13
        |-> ##2 cfg.exposure_rows[11:8] == $past(reg_req.wdata[3:0], 2)) else $error("exposure high wrong");
    a_line_gap_high: assert property (reg_req.wr && reg_req.addr == 8'h15
        |-> ##2 cfg.line_gap[10:8] == $past(reg_req.wdata[2:0], 2)) else $error("line gap high wrong");
    a_frame_gap_low: assert property (reg_req.wr && reg_req.addr == 8'h18
        |-> ##2 cfg.frame_gap[7:0] == $past(reg_req.wdata, 2)) else $error("frame gap low wrong");
    a_red_gain_code: assert property (reg_req.wr && reg_req.addr == 8'h1c
        |-> ##2 cfg.red_gain_code == $past(reg_req.wdata, 2)) else $error("red gain wrong");
    // Both bounds must move together, by zero or one
    a_scan_both_bounds: assert property ($past(arst_n) |->
        (scan_row_start - {1'b0, $past(scan_row_start_raw)}) == (scan_row_end - {1'b0, $past(scan_row_end_raw)})
        && (scan_row_start - {1'b0, $past(scan_row_start_raw)}) <= 10'h001) else $error("scan rows wrong");
    c_scan_inc: cover property (reg_req.wr && reg_req.addr == 8'h12 && reg_req.wdata[6]);
    c_unmapped: cover property (reg_req.rd && reg_req.addr == 8'h1d);
    c_reset_col: cover property (reg_rvalid && reg_rdata == 8'ha5);
endmodule : swg_window_timing_gain_regs_chk

bind swg_window_timing_gain_regs swg_window_timing_gain_regs_chk u_chk (.mclk(mclk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .scan_row_start_raw(scan_row_start_raw),
    .scan_row_end_raw(scan_row_end_raw), .cfg(cfg), .scan_row_start(scan_row_start), .scan_row_end(scan_row_end));

// File: swg_host_model.sv
`timescale 1ns/1ps
module swg_host_model
    import swg_pkg::*;
(
    input wire logic mclk,
    output swg_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '0;
    // Released lines show inverted values so stale data never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge mclk);
        #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = reg_rdata;
        v = reg_rvalid;
    endtask : read_reg
endmodule : swg_host_model

// File: swg_window_timing_gain_regs_tb.sv
`timescale 1ns/1ps
module swg_window_timing_gain_regs_tb
    import swg_pkg::*;
;
    logic mclk, arst_n, reg_rvalid;
    swg_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic [8:0] scan_row_start_raw, scan_row_end_raw;
    swg_cfg_t cfg;
    logic [9:0] scan_row_start, scan_row_end;
    int miscompares = 0, comparisons = 0, cycles = 0;
    logic [15:0] wlist [8] = '{16'h120d, 16'h0e81, 16'h1140, 16'h130a, 16'h14bc, 16'h1c7f, 16'h193f, 16'h1d55};

    swg_window_timing_gain_regs DUT (.mclk(mclk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .scan_row_start_raw(scan_row_start_raw), .scan_row_end_raw(scan_row_end_raw),
        .cfg(cfg), .scan_row_start(scan_row_start), .scan_row_end(scan_row_end));
    swg_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========================================================
    // Checking helpers
    // ==========================================================
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Whole run needs about 120 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg
    task automatic chk_cfg(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_cfg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.read_reg(a, d, v);
        chk_reg("rvalid", 8'h01, {7'h00, v});
        chk_reg($sformatf("register %h", a), exp, d);
    endtask : rd_chk
    function automatic logic [7:0] wmask(input logic [7:0] a);
        return (a == 8'h12) ? 8'h7f : (a == 8'h13 || a == 8'h17) ? 8'h0f : (a == 8'h15) ? 8'h07 : 8'hff;
    endfunction : wmask
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        arst_n = 1'b0;
        scan_row_start_raw = 9'h1ff;
        scan_row_end_raw = 9'h0a5;
        repeat (4) @(posedge mclk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < NUM_REGS; i++) rd_chk(REG_OFFSET[i], REG_RESET[i]);
        chk_cfg("last row", 12'h1f7, {3'h0, cfg.disp_last_row_field});
        chk_cfg("last col", 12'h297, {2'h0, cfg.disp_last_col_field});
        chk_cfg("scan start", 12'h1ff, {2'h0, scan_row_start});
        chk_cfg("scan end", 12'h0a5, {2'h0, scan_row_end});
        chk_cfg("first row", 12'h000, {3'h0, cfg.disp_first_row_field});
        chk_cfg("first col", 12'h000, {2'h0, cfg.disp_first_col_field});
        $display("test reset_values done");
        for (int i = 0; i < NUM_REGS; i++) host.write_reg(REG_OFFSET[i], 8'hff);
        for (int i = 0; i < NUM_REGS; i++) rd_chk(REG_OFFSET[i], wmask(REG_OFFSET[i]));
        chk_cfg("exposure", 12'hfff, cfg.exposure_rows);
        chk_cfg("line gap", 12'h7ff, {1'b0, cfg.line_gap});
        chk_cfg("frame gap", 12'hfff, cfg.frame_gap);
        chk_cfg("first col", 12'h3ff, {2'h0, cfg.disp_first_col_field});
        chk_cfg("scan start", 12'h200, {2'h0, scan_row_start});
        chk_cfg("scan end", 12'h0a6, {2'h0, scan_row_end});
        $display("test all_ones done");
        foreach (wlist[i]) host.write_reg(wlist[i][15:8], wlist[i][7:0]);
        scan_row_end_raw = 9'h1f0;
        @(posedge mclk);
        #1 chk_cfg("first row", 12'h103, {3'h0, cfg.disp_first_row_field});
        chk_cfg("last row", 12'h1fe, {3'h0, cfg.disp_last_row_field});
        chk_cfg("last col", 12'h100, {2'h0, cfg.disp_last_col_field});
        chk_cfg("exposure", 12'habc, cfg.exposure_rows);
        chk_cfg("red gain", 12'h07f, {4'h0, cfg.red_gain_code});
        chk_cfg("overall gain", 12'h03f, {4'h0, cfg.overall_gain_code});
        chk_cfg("blue gain", 12'h0ff, {4'h0, cfg.blue_gain_code});
        chk_cfg("green gain", 12'h0ff, {4'h0, cfg.green_gain_code});
        chk_cfg("scan start", 12'h1ff, {2'h0, scan_row_start});
        chk_cfg("scan end", 12'h1f0, {2'h0, scan_row_end});
        rd_chk(8'h0d, 8'h00);
        rd_chk(8'h1d, 8'h00);
        $display("test fields done");
        arst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 arst_n = 1'b1;
        rd_chk(8'h12, 8'h32);
        rd_chk(8'h1c, 8'h00);
        chk_cfg("last col", 12'h297, {2'h0, cfg.disp_last_col_field});
        $display("test second_reset done");
        conclude();
    end
endmodule : swg_window_timing_gain_regs_tb
